//--- cfr_flag_reg.sv
// Functional notes
// RULE_01 - bits 7 to 5 have no storage and read as zero
// RULE_02 - flag-affecting instruction aimed at flags: result flags beat data
// RULE_03 - watchdog and power-down flags ignore every write
// RULE_04 - timeout flag: set by power-up, clear, sleep; cleared by timeout
// RULE_05 - power-down flag set by power-up or watchdog clear; sleep clears
// RULE_06 - zero flag follows whether the result is zero
// RULE_07 - add/sub: nibble carry is carry out of bit three
// RULE_08 - add/sub: carry is carry out of the top result bit
// RULE_09 - subtract adds two's complement; carries mean no borrow
// RULE_10 - rotates load carry with the bit shifted out
// RULE_11 - clear aimed at flags sets zero, leaves other flags alone
// RULE_12 - software should alter flags only with non-flag instructions
// RULE_13 - power-on reset: cause flags one, arithmetic flags zero
// RULE_14 - unaffected flags hold; plain writes lose to flag updates
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cfr_map.svh"

module cfr_flag_reg
  import cfr_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`CFR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`CFR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire cfr_exec_t              exec_req,
  output cfr_res_t                    exec_res,
  output logic [7:0]                  flags_out,
  input  wire logic                   watchdog_clear_instr,
  input  wire logic                   sleep_instr,
  input  wire logic                   watchdog_timeout,
  output logic                        irq
);

  localparam int AW = `CFR_ADDR_W;

  // word-aligned address match
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = (a[AW-1:2] == ofs[AW-1:2]);
  endfunction : hit

  function automatic logic known(input logic [AW-1:0] a);
    known = hit(a, `CFR_OFS_FLAGS) || hit(a, `CFR_OFS_IRQ_STAT) ||
            hit(a, `CFR_OFS_IRQ_MASK) || hit(a, `CFR_OFS_RESULT);
  endfunction : known

  // flag bits and bus-side state
  logic                 tmo_q;
  logic                 tmo_d;
  logic                 pwrdn_q;
  logic                 pwrdn_d;
  logic                 z_q;
  logic                 z_d;
  logic                 nc_q;
  logic                 nc_d;
  logic                 c_q;
  logic                 c_d;
  logic [`CFR_IRQ_W-1:0] stat_q;
  logic [`CFR_IRQ_W-1:0] stat_d;
  logic [`CFR_IRQ_W-1:0] mask_q;
  logic [`CFR_IRQ_W-1:0] mask_d;
  logic [7:0]           result_q;
  logic                 res_vld_q;

  logic                 aw_hold_q;
  logic [AW-1:0]        awaddr_q;
  logic                 w_hold_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [1:0]           rresp_q;
  logic [31:0]          rdata_q;

  cfr_alu_t             alu;

  // execution datapath
  cfr_alu u_alu (
    .req  (exec_req),
    .c_in (c_q),
    .out  (alu)
  );

  wire logic go      = exec_req.valid;
  wire logic upd_z   = go && alu.aff_z;
  wire logic upd_nc  = go && alu.aff_nc;
  wire logic upd_c   = go && alu.aff_c;
  // a clear into flags writes only the zero flag
  wire logic dst_wr  = go && exec_req.dest_flags &&
                       (exec_req.op != OP_CLR);  // RULE_11

  // write channels
  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire  = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire logic lane0   = wstrb_q[0];
  wire logic wr_flg  = wr_fire && lane0 && hit(awaddr_q, `CFR_OFS_FLAGS);
  wire logic wr_stat = wr_fire && lane0 &&
                       hit(awaddr_q, `CFR_OFS_IRQ_STAT);
  wire logic wr_mask = wr_fire && lane0 &&
                       hit(awaddr_q, `CFR_OFS_IRQ_MASK);
  wire logic [1:0] wr_resp = known(awaddr_q) ? `CFR_RESP_OKAY
                                             : `CFR_RESP_SLVERR;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // flag next values
  // instruction update first, then instruction data, then bus write
  assign z_d  = upd_z  ? alu.z  :  // RULE_02
                dst_wr ? alu.res[`CFR_BIT_Z] :
                wr_flg ? wdata_q[`CFR_BIT_Z] : z_q;  // RULE_14
  assign nc_d = upd_nc ? alu.nc :  // RULE_02
                dst_wr ? alu.res[`CFR_BIT_NC] :
                wr_flg ? wdata_q[`CFR_BIT_NC] : nc_q;  // RULE_14
  assign c_d  = upd_c  ? alu.c  :  // RULE_02
                dst_wr ? alu.res[`CFR_BIT_C] :
                wr_flg ? wdata_q[`CFR_BIT_C] : c_q;  // RULE_14

  // cause flags see only the watchdog/sleep events, never data
  // a timeout in the same cycle as a clear wins: it is the later news
  assign tmo_d   = watchdog_timeout ? 1'h0 :  // RULE_04
                   (watchdog_clear_instr || sleep_instr) ? 1'h1 :
                   tmo_q;  // RULE_03
  assign pwrdn_d = sleep_instr ? 1'h0 :  // RULE_05
                   watchdog_clear_instr ? 1'h1 : pwrdn_q;  // RULE_03

  // interrupt status
  logic [`CFR_IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`CFR_IRQ_WDOG]  = watchdog_timeout;
    ev[`CFR_IRQ_SLEEP] = sleep_instr;
    ev[`CFR_IRQ_FLAGW] = go && exec_req.dest_flags;
  end

  // set beats a simultaneous write-one-to-clear
  assign stat_d = ev | (stat_q & ~({`CFR_IRQ_W{wr_stat}} &
                                   wdata_q[`CFR_IRQ_W-1:0]));
  assign mask_d = wr_mask ? wdata_q[`CFR_IRQ_W-1:0] : mask_q;
  assign irq    = |(stat_q & mask_q);

  // register outputs
  wire logic [7:0] flags_rd =
    {3'h0, tmo_q, pwrdn_q, z_q, nc_q, c_q};  // RULE_01
  assign flags_out      = flags_rd;
  assign exec_res.valid = res_vld_q;
  assign exec_res.data  = result_q;

  // read channel
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] rd_mux =
    hit(s_axi_araddr, `CFR_OFS_FLAGS)    ? {24'h000000, flags_rd} :
    hit(s_axi_araddr, `CFR_OFS_IRQ_STAT) ? {29'h0000000, stat_q} :
    hit(s_axi_araddr, `CFR_OFS_IRQ_MASK) ? {29'h0000000, mask_q} :
    hit(s_axi_araddr, `CFR_OFS_RESULT)   ? {24'h000000, result_q} :
                                           32'h00000000;
  wire logic [1:0] rd_resp = known(s_axi_araddr) ? `CFR_RESP_OKAY
                                                 : `CFR_RESP_SLVERR;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // registers
  // aresetn stands for power-on / brown-out; warm resets elsewhere
  // leave this block running so the arithmetic flags survive them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmo_q   <= `CFR_RST_TMO;  // RULE_13
      pwrdn_q <= `CFR_RST_PWRDN;  // RULE_13
      z_q     <= `CFR_RST_ARITH;  // RULE_13
      nc_q    <= `CFR_RST_ARITH;
      c_q     <= `CFR_RST_ARITH;
    end else begin
      tmo_q   <= tmo_d;
      pwrdn_q <= pwrdn_d;
      z_q     <= z_d;
      nc_q    <= nc_d;
      c_q     <= c_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q    <= `CFR_RST_STAT;
      mask_q    <= `CFR_RST_MASK;
      result_q  <= `CFR_RST_RESULT;
      res_vld_q <= 1'h0;
    end else begin
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      res_vld_q <= go;
      if (go) begin
        result_q <= alu.res;
      end
    end
  end

  // address and data are captured independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'h0;
      awaddr_q  <= '0;
    end else if (aw_fire) begin
      aw_hold_q <= 1'h1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'h0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (w_fire) begin
      w_hold_q <= 1'h1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'h0;
      bresp_q  <= `CFR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'h1;
      bresp_q  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'h0;
      rresp_q  <= `CFR_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (ar_fire) begin
      rvalid_q <= 1'h1;
      rresp_q  <= rd_resp;
      rdata_q  <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'h0;
    end
  end

endmodule : cfr_flag_reg

//--- cfr_map.svh
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// register byte offsets on the AXI4-Lite port
`define CFR_ADDR_W        8
`define CFR_OFS_FLAGS     8'h00
`define CFR_OFS_IRQ_STAT  8'h04
`define CFR_OFS_IRQ_MASK  8'h08
`define CFR_OFS_RESULT    8'h0C

// flag register bit positions
`define CFR_BIT_TMO       4
`define CFR_BIT_PWRDN     3
`define CFR_BIT_Z         2
`define CFR_BIT_NC        1
`define CFR_BIT_C         0

// power-on / brown-out values
`define CFR_RST_TMO       1'h1
`define CFR_RST_PWRDN     1'h1
`define CFR_RST_ARITH     1'h0
`define CFR_RST_MASK      3'h0
`define CFR_RST_STAT      3'h0
`define CFR_RST_RESULT    8'h00

// interrupt status / mask bit positions
`define CFR_IRQ_WDOG      0
`define CFR_IRQ_SLEEP     1
`define CFR_IRQ_FLAGW     2
`define CFR_IRQ_W         3

// nibble carry leaves bit 3, shows as bit 4 of a nibble sum
`define CFR_NIB_CY        4

`define CFR_RESP_OKAY     2'h0
`define CFR_RESP_SLVERR   2'h2

`endif

//--- cfr_pkg.sv
package cfr_pkg;

  typedef enum logic [3:0] {
    OP_PASS = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_AND  = 4'h3,
    OP_IOR  = 4'h4,
    OP_XOR  = 4'h5,
    OP_RL   = 4'h6,
    OP_RR   = 4'h7,
    OP_CLR  = 4'h8,
    OP_MOVZ = 4'h9
  } cfr_op_t;

  typedef struct packed {
    logic       valid;
    cfr_op_t    op;
    logic       dest_flags;
    logic [7:0] w;
    logic [7:0] f;
  } cfr_exec_t;

  typedef struct packed {
    logic [7:0] res;
    logic       z;
    logic       nc;
    logic       c;
    logic       aff_z;
    logic       aff_nc;
    logic       aff_c;
  } cfr_alu_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cfr_res_t;

endpackage : cfr_pkg

//--- cfr_alu.sv
`timescale 1ns/1ps
`include "cfr_map.svh"

module cfr_alu
  import cfr_pkg::*;
(
  input  wire cfr_exec_t req,
  input  wire logic      c_in,
  output cfr_alu_t       out
);

  function automatic logic [8:0] add9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       ci);
    add9 = {1'h0, a} + {1'h0, b} + {8'h00, ci};
  endfunction : add9

  // subtract adds the two's complement: carries read as not-borrow
  wire logic       is_sub = (req.op == OP_SUB);
  wire logic [7:0] b_op   = is_sub ? ~req.w : req.w;  // RULE_09
  wire logic [8:0] sum    = add9(req.f, b_op, is_sub);
  wire logic [8:0] nib    = add9({4'h0, req.f[3:0]}, {4'h0, b_op[3:0]},
                                 is_sub);
  wire logic       is_ar  = (req.op == OP_ADD) || is_sub;
  wire logic       is_rot = (req.op == OP_RL) || (req.op == OP_RR);

  logic [7:0] res;
  logic       rot_c;

  always_comb begin
    rot_c = 1'h0;
    unique case (req.op)
      OP_ADD, OP_SUB: res = sum[7:0];
      OP_AND:         res = req.f & req.w;
      OP_IOR:         res = req.f | req.w;
      OP_XOR:         res = req.f ^ req.w;
      OP_RL: begin
        res   = {req.f[6:0], c_in};
        rot_c = req.f[7];  // RULE_10
      end
      OP_RR: begin
        res   = {c_in, req.f[7:1]};
        rot_c = req.f[0];  // RULE_10
      end
      OP_CLR:         res = 8'h00;
      default:        res = req.f;
    endcase
  end

  assign out.res    = res;
  assign out.z      = (res == 8'h00);  // RULE_06
  assign out.nc     = nib[`CFR_NIB_CY];  // RULE_07
  assign out.c      = is_rot ? rot_c : sum[8];  // RULE_08
  assign out.aff_z  = !is_rot && (req.op != OP_PASS);
  assign out.aff_nc = is_ar;
  assign out.aff_c  = is_ar || is_rot;

endmodule : cfr_alu

//--- cfr_flag_reg_assertions.sv
`timescale 1ns/1ps
module cfr_flag_reg_assertions
  import cfr_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire cfr_exec_t  exec_req,
  input wire cfr_res_t   exec_res,
  input wire logic [7:0] flags_out,
  input wire logic       watchdog_clear_instr,
  input wire logic       sleep_instr,
  input wire logic       watchdog_timeout,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire cfr_op_t    op = exec_req.op;
  wire logic [7:0] f = exec_req.f;
  wire logic [7:0] w = exec_req.w;
  wire logic [8:0] sum_w = {1'b0, f} + {1'b0, w};
  wire logic [4:0] nib_w = {1'b0, f[3:0]} + {1'b0, w[3:0]};
  wire logic [1:0] add_fl = {nib_w[4], sum_w[8]};
  wire logic [1:0] sub_fl = {f[3:0] >= w[3:0], f >= w};
  wire logic       go = exec_req.valid;
  wire logic       is_add = go && op == OP_ADD;
  wire logic       is_sub = go && op == OP_SUB;
  wire logic       rot = go && op inside {OP_RL, OP_RR};
  wire logic       rot_bit = op == OP_RL ? f[7] : f[0];
  wire logic       upd_z = go && !(op inside {OP_PASS, OP_RL, OP_RR});
  wire logic       clr = watchdog_clear_instr;
  wire logic       any_ev = clr | sleep_instr | watchdog_timeout;
  wire logic       tmo_set = (clr | sleep_instr) & ~watchdog_timeout;
  wire logic       pwrdn_set = clr & ~sleep_instr;

  a_upper_zero: assert property (flags_out[7:5] == 3'h0)
    else $error("flag bits 7:5 not zero");
  a_cause_hold: assert property
    (!any_ev |=> $stable(flags_out[4:3]))
    else $error("cause flags moved without an event");
  a_tmo_clear: assert property (watchdog_timeout |=> !flags_out[4])
    else $error("timeout flag not cleared by timeout");
  a_tmo_set: assert property (tmo_set |=> flags_out[4])
    else $error("timeout flag not set");
  a_pwrdn_sleep: assert property (sleep_instr |=> !flags_out[3])
    else $error("power-down flag not cleared by sleep");
  a_pwrdn_set: assert property (pwrdn_set |=> flags_out[3])
    else $error("power-down flag not set by clear");
  a_zero_flag: assert property
    (upd_z |=> flags_out[2] == (exec_res.data == 8'h00))
    else $error("zero flag does not match result");
  a_add_flags: assert property
    (is_add |=> flags_out[1:0] == $past(add_fl))
    else $error("add carries wrong");
  a_sub_borrow: assert property
    (is_sub |=> flags_out[1:0] == $past(sub_fl))
    else $error("subtract borrows wrong");
  a_rot_carry: assert property
    (rot |=> flags_out[0] == $past(rot_bit))
    else $error("rotate carry wrong");

  c_sub: cover property (is_sub);
  c_sleep: cover property (sleep_instr);
  c_irq: cover property ($rose(irq));
endmodule : cfr_flag_reg_assertions

bind cfr_flag_reg cfr_flag_reg_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .exec_req(exec_req), .exec_res(exec_res),
  .flags_out(flags_out), .watchdog_clear_instr(watchdog_clear_instr),
  .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout), .irq(irq));

//--- cfr_exec_model.sv
`timescale 1ns/1ps
module cfr_exec_model
  import cfr_pkg::*;
(
  input  wire logic aclk,
  output cfr_exec_t exec_req,
  output logic      watchdog_clear_instr,
  output logic      sleep_instr,
  output logic      watchdog_timeout
);
  initial begin
    exec_req = '0;
    {watchdog_timeout, sleep_instr, watchdog_clear_instr} = 3'h0;
  end

  // operands scrambled once valid drops, so stale values never pass
  task automatic issue(input cfr_op_t op, input logic d,
                       input logic [7:0] f, input logic [7:0] w);
    @(posedge aclk);
    exec_req <= '{1'b1, op, d, w, f};
    @(posedge aclk);
    exec_req <= cfr_exec_t'({1'b0, ~exec_req[20:0]});
  endtask : issue

  task automatic pulse(input logic [2:0] e);
    @(posedge aclk);
    {watchdog_timeout, sleep_instr, watchdog_clear_instr} <= e;
    @(posedge aclk);
    {watchdog_timeout, sleep_instr, watchdog_clear_instr} <= 3'h0;
  endtask : pulse
endmodule : cfr_exec_model

//--- cfr_flag_reg_tb_top.sv
`timescale 1ns/1ps
`include "cfr_map.svh"
module cfr_flag_reg_tb_top
  import cfr_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, flags_out;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, wclr, slp, wto;
  logic [1:0]  bresp, rresp;
  cfr_exec_t   exec_req;
  cfr_res_t    exec_res;
  int          n_errors = 0, comparisons = 0;

  initial forever #50 aclk = ~aclk;

  cfr_flag_reg uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .exec_req(exec_req),
    .exec_res(exec_res), .flags_out(flags_out), .watchdog_clear_instr(wclr),
    .sleep_instr(slp), .watchdog_timeout(wto), .irq(irq));

  cfr_exec_model m (.aclk(aclk), .exec_req(exec_req),
    .watchdog_clear_instr(wclr), .sleep_instr(slp), .watchdog_timeout(wto));

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // ready is sampled mid-cycle, the handshake completes at the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic ta, tw, done;
    logic [1:0] r;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!done) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (++n > 40) begin
        n_errors++;
        complete_run();
      end
    end
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic ta, done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!done) begin
      @(negedge aclk);
      ta = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      if (++n > 40) begin
        n_errors++;
        complete_run();
      end
    end
    cmp("rdata", e, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask : axi_rd

  task automatic ev(input logic [2:0] e, input logic [7:0] fl);
    m.pulse(e);
    @(negedge aclk);
    cmp("flags", {24'h0, fl}, {24'h0, flags_out});
  endtask : ev

  task automatic ex(input cfr_op_t op, input logic d, input logic [7:0] f,
                    input logic [7:0] w, input logic [7:0] res,
                    input logic [7:0] fl);
    m.issue(op, d, f, w);
    @(negedge aclk);
    cmp("result", {23'h0, 1'b1, res}, {23'h0, exec_res});
    cmp("flags", {24'h0, fl}, {24'h0, flags_out});
  endtask : ex

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CFR_OFS_FLAGS, 32'h18, `CFR_RESP_OKAY);
    ev(3'b010, 8'h10);
    ev(3'b100, 8'h00);
    ev(3'b001, 8'h18);
    ev(3'b101, 8'h08);
    ev(3'b011, 8'h10);
    ev(3'b001, 8'h18);
    ex(OP_ADD, 1'b0, 8'h0F, 8'h01, 8'h10, 8'h1A);
    ex(OP_ADD, 1'b0, 8'hF0, 8'h10, 8'h00, 8'h1D);
    ex(OP_SUB, 1'b0, 8'h05, 8'h05, 8'h00, 8'h1F);
    ex(OP_SUB, 1'b0, 8'h00, 8'h01, 8'hFF, 8'h18);
    ex(OP_SUB, 1'b0, 8'h10, 8'h01, 8'h0F, 8'h19);
    ex(OP_RL, 1'b0, 8'h00, 8'h00, 8'h01, 8'h18);
    ex(OP_RR, 1'b0, 8'h03, 8'h00, 8'h01, 8'h19);
    ex(OP_XOR, 1'b0, 8'h55, 8'h55, 8'h00, 8'h1D);
    ex(OP_IOR, 1'b0, 8'h01, 8'h00, 8'h01, 8'h19);
    ex(OP_AND, 1'b0, 8'h0F, 8'hF0, 8'h00, 8'h1D);
    ex(OP_ADD, 1'b1, 8'h0F, 8'h01, 8'h10, 8'h1A);
    ex(OP_PASS, 1'b1, 8'h03, 8'h00, 8'h03, 8'h1B);
    ex(OP_CLR, 1'b1, 8'hAA, 8'h00, 8'h00, 8'h1F);
    ex(OP_MOVZ, 1'b0, 8'h5A, 8'h00, 8'h5A, 8'h1B);
    axi_wr(`CFR_OFS_RESULT, 32'hFF, `CFR_RESP_OKAY);
    axi_rd(`CFR_OFS_RESULT, 32'h5A, `CFR_RESP_OKAY);
    axi_rd(`CFR_OFS_IRQ_STAT, 32'h7, `CFR_RESP_OKAY);
    axi_rd(`CFR_OFS_IRQ_MASK, 32'h0, `CFR_RESP_OKAY);
    cmp("irq", 32'h0, {31'h0, irq});
    axi_wr(`CFR_OFS_IRQ_MASK, 32'h2, `CFR_RESP_OKAY);
    cmp("irq", 32'h1, {31'h0, irq});
    axi_wr(`CFR_OFS_IRQ_STAT, 32'h2, `CFR_RESP_OKAY);
    cmp("irq", 32'h0, {31'h0, irq});
    axi_rd(`CFR_OFS_IRQ_STAT, 32'h5, `CFR_RESP_OKAY);
    ev(3'b100, 8'h0B);
    cmp("irq", 32'h0, {31'h0, irq});
    ev(3'b010, 8'h13);
    cmp("irq", 32'h1, {31'h0, irq});
    axi_wr(`CFR_OFS_FLAGS, 32'hF8, `CFR_RESP_OKAY);
    axi_rd(`CFR_OFS_FLAGS, 32'h10, `CFR_RESP_OKAY);
    axi_wr(`CFR_OFS_FLAGS, 32'h0F, `CFR_RESP_OKAY);
    axi_rd(`CFR_OFS_FLAGS, 32'h17, `CFR_RESP_OKAY);
    axi_wr(8'h10, 32'h1, `CFR_RESP_SLVERR);
    axi_rd(8'h10, 32'h0, `CFR_RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp("flags", 32'h18, {24'h0, flags_out});
    complete_run();
  end
endmodule : cfr_flag_reg_tb_top
